// ### src/thf_status_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [R01] Bit 7 of the overtemperature status register shows that the local channel tripped its pin limit.
// [R02] Bit 6 of the overtemperature status register shows that the remote channel tripped its pin limit.
// [R03] Bit 4 is set when the overtemperature signal duty exceeds the programmed limit and is cleared by a read.
// [R04] With a limit of zero and the signal still active, bit 4 sets again at once after a clearing read.
// [R05] Bit 3 shows that another party pulls the overtemperature pin low while the pin is an input.
// [R06] Bit 2 shows that the device itself drives the overtemperature pin low.
// [R07] Bit 7 of the fan and alert status register shows a stalled fan.
// [R08] Bit 6 of the fan and alert status register shows fans forced to full speed by an alarm.
// [R09] Bit 0 of the fan and alert status register shows that the alert output is driven low.
// [R10] Both registers reset to zero on power-on and software reset, ignore locking, and are read-only.
// [R11] The active percentage of the overtemperature signal is measured over a selectable window.
// [R12] Every status bit except the duty flag follows its condition live and clears when it ends.
module thf_status_regs
#(
   parameter int CNT_W       = 24,
   parameter int TICK_CYCLES = thf_pkg::TICK_CYCLES_DEFAULT
)
(
   input  wire logic                  core_clk_in,
   input  wire logic                  resetn_in,
   input  wire logic                  soft_reset_in,
   input  wire thf_pkg::thf_cond_type cond_in,
   input  wire logic                  overtemp_pin_in,
   input  wire logic                  overtemp_drive_in,
   output logic                       overtemp_pin_out,
   output logic                       overtemp_pin_oe_n_out,
   input  wire logic [7:0]            overtemp_duty_limit_in,
   input  wire logic [1:0]            window_sel_in,
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic                  reg_rd_in,
   output logic [7:0]                 rd_data_out,
   output logic                       rd_valid_out,
   output logic [7:0]                 overtemp_on_time_out
);
   import thf_pkg::*;

   thf_overtemp_status_type  status2;
   thf_fan_alert_status_type status3;
   logic [CNT_W-1:0]         tick_cnt;
   logic [CNT_W-1:0]         tick_limit;
   logic                     tick;
   logic [6:0]               win_cnt;
   logic [6:0]               active_ticks;
   logic                     overtemp_active;
   logic                     win_end;
   logic                     duty_set;
   logic                     rd_clear;

   // open-drain pin: only ever pulls low
   assign overtemp_pin_out      = 1'b0;
   assign overtemp_pin_oe_n_out = ~overtemp_drive_in; // R06
   assign overtemp_active       = ~overtemp_pin_in;

   // tick period doubles with each step of the window select
   assign tick_limit = CNT_W'(TICK_CYCLES) << window_sel_in;
   assign tick       = (tick_cnt == tick_limit - CNT_W'(1));
   assign win_end    = tick && (win_cnt == WINDOW_TICKS - TICK_STEP);

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         tick_cnt <= '0;
      else if (soft_reset_in || tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + CNT_W'(1);
   end

   // duty measurement: active ticks out of one hundred read directly as percent
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         win_cnt              <= WIN_CNT_RESET;
         active_ticks         <= ACTIVE_TICKS_RESET;
         overtemp_on_time_out <= ON_TIME_RESET;
      end
      else if (soft_reset_in)
      begin
         win_cnt              <= WIN_CNT_RESET;
         active_ticks         <= ACTIVE_TICKS_RESET;
         overtemp_on_time_out <= ON_TIME_RESET;
      end
      else if (win_end)
      begin
         win_cnt              <= WIN_CNT_RESET;
         active_ticks         <= ACTIVE_TICKS_RESET;
         overtemp_on_time_out <= {1'b0, active_ticks + (overtemp_active ? TICK_STEP : ACTIVE_TICKS_RESET)}; // R11
      end
      else if (tick)
      begin
         win_cnt <= win_cnt + TICK_STEP;
         if (overtemp_active)
            active_ticks <= active_ticks + TICK_STEP; // R11
      end
   end

   assign duty_set = ((overtemp_duty_limit_in == DUTY_LIMIT_ZERO) && overtemp_active) // R04
                     || ({1'b0, active_ticks} > overtemp_duty_limit_in); // R03
   assign rd_clear = reg_rd_in && (reg_addr_in == OVERTEMP_STATUS_ADDR);

   // status bits: live, except the duty flag, which holds until a clearing read
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         status2 <= STATUS_RESET;
         status3 <= STATUS_RESET;
      end
      else if (soft_reset_in)
      begin
         status2 <= STATUS_RESET; // R10
         status3 <= STATUS_RESET; // R10
      end
      else
      begin
         status2.local_trip      <= cond_in.local_trip; // R01 R12
         status2.remote_trip     <= cond_in.remote_trip; // R02 R12
         status2.input_seen      <= overtemp_active && !overtemp_drive_in; // R05 R12
         status2.output_driven   <= overtemp_drive_in; // R06 R12
         status3.fan_stalled     <= cond_in.fan_stalled; // R07 R12
         status3.fan_alarm_speed <= cond_in.fan_alarm_speed; // R08 R12
         status3.alert_low       <= cond_in.alert_low; // R09 R12
         // set wins over the clearing read
         if (duty_set)
            status2.duty_exceeded <= 1'b1; // R03 R04
         else if (rd_clear)
            status2.duty_exceeded <= 1'b0; // R03
      end
   end

   // read port; no write path exists, so the registers stay read-only
   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rd_data_out  <= READ_IDLE;
         rd_valid_out <= 1'b0;
      end
      else
      begin
         rd_valid_out <= reg_rd_in;
         if (reg_rd_in)
         begin
            case (reg_addr_in)
               OVERTEMP_STATUS_ADDR:  rd_data_out <= status2; // R10
               FAN_ALERT_STATUS_ADDR: rd_data_out <= status3; // R10
               default:               rd_data_out <= READ_IDLE;
            endcase
         end
      end
   end

   sequence win_end_seq;
      win_end && !soft_reset_in;
   endsequence

   sequence on_time_seq;
      overtemp_on_time_out == {1'b0, $past(active_ticks) + ($past(overtemp_active) ? TICK_STEP : ACTIVE_TICKS_RESET)};
   endsequence

   local_trip_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R01
      cond_in.local_trip |=> status2.local_trip)
      else $error("local trip bit not set");
   remote_trip_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R02
      cond_in.remote_trip |=> status2.remote_trip)
      else $error("remote trip bit not set");
   duty_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R03
      (rd_clear && !duty_set) |=> !status2.duty_exceeded)
      else $error("duty flag not cleared by read");
   duty_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R03
      ({1'b0, active_ticks} > overtemp_duty_limit_in) |=> status2.duty_exceeded)
      else $error("duty flag not set on excess");
   duty_zero_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R04
      (rd_clear && overtemp_duty_limit_in == DUTY_LIMIT_ZERO && overtemp_active) |=> status2.duty_exceeded)
      else $error("duty flag lost at zero limit");
   input_seen_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R05
      1'b1 |=> status2.input_seen == ($past(overtemp_active) && !$past(overtemp_drive_in)))
      else $error("input seen bit wrong");
   pin_driven_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R06
      overtemp_drive_in |-> !overtemp_pin_oe_n_out ##1 status2.output_driven)
      else $error("output driven bit or pin enable wrong");
   fan_stall_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R07
      1'b1 |=> status3.fan_stalled == $past(cond_in.fan_stalled))
      else $error("fan stall bit wrong");
   fan_alarm_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R08
      $rose(cond_in.fan_alarm_speed) |=> status3.fan_alarm_speed)
      else $error("fan alarm bit wrong");
   alert_low_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R09
      1'b1 |=> status3.alert_low == $past(cond_in.alert_low))
      else $error("alert low bit wrong");
   soft_reset_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      soft_reset_in |=> (status2 == STATUS_RESET) && (status3 == STATUS_RESET))
      else $error("status not cleared by soft reset");
   reserved_zero_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      (status2.rsvd5 == 1'b0) && (status2.rsvd == 2'b00) && (status3.rsvd == 5'h00))
      else $error("reserved bit set");
   on_time_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R11
      win_end_seq |=> on_time_seq)
      else $error("on-time result wrong");
   live_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R12
      $fell(cond_in.local_trip) |=> !status2.local_trip)
      else $error("live bit did not clear");

   // antecedents of later checks: read requests by target for the read port checks, then the idle-tick condition for the counter checks
   sequence rd_status2_seq;
      reg_rd_in && (reg_addr_in == OVERTEMP_STATUS_ADDR);
   endsequence

   sequence rd_status3_seq;
      reg_rd_in && (reg_addr_in == FAN_ALERT_STATUS_ADDR);
   endsequence

   sequence rd_unmapped_seq;
      reg_rd_in && (reg_addr_in != OVERTEMP_STATUS_ADDR) && (reg_addr_in != FAN_ALERT_STATUS_ADDR);
   endsequence

   sequence tick_idle_seq;
      !tick && !soft_reset_in;
   endsequence

   rd_valid_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      reg_rd_in |=> rd_valid_out)
      else $error("read not answered");

   rd_quiet_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      !reg_rd_in |=> !rd_valid_out)
      else $error("read answer without request");

   rd_status2_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      rd_status2_seq |=> (rd_data_out == $past(status2)))
      else $error("overtemp status read data wrong");

   rd_status3_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      rd_status3_seq |=> (rd_data_out == $past(status3)))
      else $error("fan alert status read data wrong");

   rd_unmapped_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      rd_unmapped_seq |=> (rd_data_out == READ_IDLE))
      else $error("unmapped read not zero");

   rd_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      !reg_rd_in |=> $stable(rd_data_out))
      else $error("read data changed without read");

   soft_count_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
      soft_reset_in |=> (tick_cnt == '0) && (win_cnt == WIN_CNT_RESET) && (active_ticks == ACTIVE_TICKS_RESET))
      else $error("counters not cleared by soft reset");

   soft_on_time_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R11
      soft_reset_in |=> (overtemp_on_time_out == ON_TIME_RESET))
      else $error("on-time not cleared by soft reset");

   remote_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R12
      $fell(cond_in.remote_trip) |=> !status2.remote_trip)
      else $error("remote bit did not clear");

   alarm_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R12
      $fell(cond_in.fan_alarm_speed) |=> !status3.fan_alarm_speed)
      else $error("alarm bit did not clear");

   driven_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R06
      !overtemp_drive_in |=> !status2.output_driven)
      else $error("output driven bit stuck");

   input_mask_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R05
      overtemp_drive_in |=> !status2.input_seen)
      else $error("input seen while self driving");

   duty_sticky_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R03
      (status2.duty_exceeded && !rd_clear) |=> status2.duty_exceeded)
      else $error("duty flag dropped without read");

   duty_quiet_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R03
      (!status2.duty_exceeded && !duty_set) |=> !status2.duty_exceeded)
      else $error("duty flag set without cause");

   win_restart_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R11
      win_end_seq |=> (win_cnt == WIN_CNT_RESET) && (active_ticks == ACTIVE_TICKS_RESET))
      else $error("window did not restart");

   active_within_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R11
      active_ticks <= win_cnt)
      else $error("active ticks exceed elapsed ticks");

   on_time_range_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R11
      overtemp_on_time_out <= {1'b0, WINDOW_TICKS})
      else $error("on-time above one hundred percent");

   tick_restart_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R11
      tick |=> (tick_cnt == '0))
      else $error("tick counter did not restart");

   tick_step_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R11
      tick_idle_seq |=> (tick_cnt == $past(tick_cnt) + CNT_W'(1)))
      else $error("tick counter did not advance");

   win_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R11
      tick_idle_seq |=> $stable(win_cnt) && $stable(active_ticks))
      else $error("window count moved between ticks");

   win_step_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in || soft_reset_in) // R11
      (tick && !win_end) |=> (win_cnt == $past(win_cnt) + TICK_STEP))
      else $error("window count did not advance");

endmodule

`default_nettype wire

// ### src/thf_pkg.sv
package thf_pkg;

   localparam logic [7:0] OVERTEMP_STATUS_ADDR  = 8'h50;
   localparam logic [7:0] FAN_ALERT_STATUS_ADDR = 8'h51;
   localparam logic [7:0] STATUS_RESET          = 8'h00;
   localparam logic [7:0] ON_TIME_RESET         = 8'h00;
   localparam logic [7:0] DUTY_LIMIT_ZERO       = 8'h00;
   localparam logic [7:0] READ_IDLE             = 8'h00;

   // base tick of the duty window and the number of ticks in one window
   localparam int         CLK_PERIOD_NS         = 50;
   localparam int         TICK_TIME_NS          = 1000000;
   localparam int         TICK_CYCLES_DEFAULT   = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam logic [6:0] WINDOW_TICKS          = 7'h64;
   localparam logic [6:0] ACTIVE_TICKS_RESET    = 7'h00;
   localparam logic [6:0] WIN_CNT_RESET         = 7'h00;
   localparam logic [6:0] TICK_STEP             = 7'h01;

   typedef struct packed {
      logic       local_trip;
      logic       remote_trip;
      logic       rsvd5;
      logic       duty_exceeded;
      logic       input_seen;
      logic       output_driven;
      logic [1:0] rsvd;
   } thf_overtemp_status_type;

   typedef struct packed {
      logic       fan_stalled;
      logic       fan_alarm_speed;
      logic [4:0] rsvd;
      logic       alert_low;
   } thf_fan_alert_status_type;

   typedef struct packed {
      logic local_trip;
      logic remote_trip;
      logic fan_stalled;
      logic fan_alarm_speed;
      logic alert_low;
   } thf_cond_type;

endpackage

// ### verif/thf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module thf_host_model
(
   input  wire logic       clk_in,
   input  wire logic       go_in,
   input  wire logic [7:0] addr_in,
   output logic            rd_out = 1'b0,
   output logic [7:0]      addr_out = 8'h5a
);
   // one-cycle read strobe; the released address bus toggles every cycle
   always_ff @(posedge clk_in)
   begin
      rd_out   <= go_in;
      addr_out <= go_in ? addr_in : ~addr_out;
   end
endmodule
`default_nettype wire

// ### verif/thf_status_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module thf_status_regs_tb;
   import thf_pkg::*;
   logic         clk = 1'b0;
   logic         rstn, soft_rst, pin, drive, go, rd, rvalid, pin_o, oe_n;
   thf_cond_type cond;
   logic [7:0]   limit, addr, raddr, rdata, on_time;
   logic [1:0]   wsel;
   logic [31:0]  seed = 32'h000174d1;
   logic [7:0]   expq[$];
   int           errors = 0;
   int           cmp_count = 0;

   thf_host_model u_host (.clk_in(clk), .go_in(go), .addr_in(addr), .rd_out(rd), .addr_out(raddr));
   thf_status_regs #(.TICK_CYCLES(4)) u_dut (.core_clk_in(clk), .resetn_in(rstn), .soft_reset_in(soft_rst),
      .cond_in(cond), .overtemp_pin_in(pin), .overtemp_drive_in(drive), .overtemp_pin_out(pin_o),
      .overtemp_pin_oe_n_out(oe_n), .overtemp_duty_limit_in(limit), .window_sel_in(wsel),
      .reg_addr_in(raddr), .reg_rd_in(rd), .rd_data_out(rdata), .rd_valid_out(rvalid),
      .overtemp_on_time_out(on_time));

   initial
   begin
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic rdreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      go <= 1'b1;
      addr <= a;
      expq.push_back(e);
      @(posedge clk);
      go <= 1'b0;
      // return only once the strobe has reached the block, so later stimulus cannot race the read
      @(posedge clk);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // each read result is matched against the oldest note
   always @(posedge clk)
   begin
      if (rvalid === 1'b1)
      begin
         if (expq.size() == 0)
         begin
            errors++;
            $display("unexpected at %0t: read with no note", $time);
         end
         else
            chk(rdata, expq.pop_front());
      end
   end

   initial
   begin
      cyc(5000);
      errors++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
   end

   initial
   begin
      rstn = 1'b0; soft_rst = 1'b0; cond = '0; pin = 1'b1; drive = 1'b0;
      limit = 8'hff; wsel = 2'h1; go = 1'b0; addr = 8'h00;
      cyc(16);
      rstn <= 1'b1;
      cyc(2);
      rdreg(OVERTEMP_STATUS_ADDR, STATUS_RESET);
      rdreg(FAN_ALERT_STATUS_ADDR, STATUS_RESET);
      rdreg(8'h52, READ_IDLE);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         seed = xorshift(seed);
         cond <= thf_cond_type'(seed[4:0]);
         cyc(3);
         rdreg(OVERTEMP_STATUS_ADDR, {cond.local_trip, cond.remote_trip, 6'h00});
         rdreg(FAN_ALERT_STATUS_ADDR, {cond.fan_stalled, cond.fan_alarm_speed, 5'h00, cond.alert_low});
      end
      $display("test live bits done");
      cond <= '0;
      drive <= 1'b1;
      pin <= 1'b0;
      cyc(3);
      chk({6'h00, pin_o, oe_n}, 8'h00);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h04);
      drive <= 1'b0;
      cyc(3);
      chk({6'h00, pin_o, oe_n}, 8'h01);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h08);
      limit <= DUTY_LIMIT_ZERO;
      cyc(3);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h18);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h18);
      limit <= 8'hff;
      pin <= 1'b1;
      cyc(3);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h10);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h00);
      $display("test pin and duty done");
      limit <= DUTY_LIMIT_ZERO;
      pin <= 1'b0;
      cyc(3);
      limit <= 8'hff;
      pin <= 1'b1;
      soft_rst <= 1'b1;
      cyc(1);
      soft_rst <= 1'b0;
      cyc(2);
      rdreg(OVERTEMP_STATUS_ADDR, STATUS_RESET);
      chk(on_time, ON_TIME_RESET);
      // one full window of 100 ticks of 8 cycles with the pin held low
      pin <= 1'b0;
      limit <= 8'h0a;
      cyc(830);
      chk(on_time, 8'h64);
      rdreg(OVERTEMP_STATUS_ADDR, 8'h18);
      pin <= 1'b1;
      $display("test soft reset and window done");
      for (int i = 0; i < 20 && expq.size() > 0; i++)
         cyc(1);
      if (expq.size() > 0)
      begin
         errors++;
         $display("unexpected at %0t: reads missing", $time);
      end
      test_done();
   end
endmodule
`default_nettype wire
